// file: rtl/crj_regs.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
module crj_regs #(
  parameter int CNT_W = 16
) (
  input  wire logic              clk,              // System clock, 100 MHz.
  input  wire logic              rst_b,            // Asynchronous reset, active low.
  input  wire logic [7:0]        address,          // Avalon byte address.
  input  wire logic              read,             // Avalon read request.
  input  wire logic              write,            // Avalon write request.
  input  wire logic [31:0]       writedata,        // Avalon write data.
  input  wire logic [3:0]        byteenable,       // Avalon byte enables.
  output logic [31:0]            readdata,         // Avalon read data.
  output logic                   waitrequest,      // Avalon wait request.
  input  wire logic              codec_busy,       // Codec output busy level.
  input  wire logic [CNT_W-1:0]  fifo_count,       // FIFO bytes held.
  input  wire logic [CNT_W-1:0]  fifo_size,        // Configured FIFO size in bytes.
  input  wire logic              size_limit_evt,   // File grew past limit, pulse.
  input  wire logic              fifo_thresh_evt,  // FIFO threshold crossed, pulse.
  input  wire logic              fifo_full_evt,    // FIFO became full, pulse.
  input  wire logic              fifo_empty_evt,   // FIFO became empty, pulse.
  input  wire logic              marker_evt,       // Decode marker read, pulse.
  input  wire logic              lb_overflow_evt,  // Line buffer overflow, pulse.
  input  wire logic              codec_irq,        // Codec interrupt level.
  input  wire logic              lb_irq,           // Line buffer interrupt level.
  input  wire logic [7:0]        chroma_in,        // Chroma sample in.
  input  wire logic              chroma_in_vld,    // Chroma sample valid.
  output logic [7:0]             chroma_out,       // Chroma sample out.
  output logic                   chroma_out_vld,   // Chroma out valid.
  output logic [10:0]            win_start_y,      // Window start row.
  output logic [10:0]            win_end_x,        // Window end column.
  output logic [10:0]            win_end_y,        // Window end row.
  output logic [1:0]             scale_mode,       // Scaling mode.
  output logic [3:0]             scale_div,        // Effective divisor n.
  output logic                   scale_ok,         // Rate and mode legal.
  output logic                   huff_fast_en,     // Encode fast mode.
  output logic                   marker_fast_en,   // Marker fast output in effect.
  output logic                   rotate_en,        // 180 degree rotation.
  output logic [2:0]             op_mode,          // Operation mode.
  output logic                   op_mode_ok,       // Operation mode legal.
  output logic                   module_clk_en,    // Module clock enable.
  output logic                   codec_clk_en,     // Codec clock and access enable.
  output logic                   module_soft_rst   // Module reset pulse.
);

  // All registered state except the reset synchroniser is one struct so reset and update always stay in step.
  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic [10:0] start_y;
    logic [10:0] end_x;
    logic [10:0] end_y;
    logic [15:0] rate;
    logic [1:0]  mode;
    logic        fast;
    logic        marker;
    logic        rot;
    logic        uvoff;
    logic [2:0]  op;
    logic        en;
    logic [3:0]  flags;
    logic        flg_marker;
    logic        flg_ovf;
    logic        busy;
    logic [1:0]  fill;
    logic        codec_irq;
    logic        lb_irq;
    logic [3:0]  div;
    logic        sc_ok;
    logic        op_ok;
    logic        srst;
    logic [7:0]  chroma;
    logic        chroma_vld;
    logic        mk_fast;
    logic        codec_en;
  } crj_state_type;

  crj_state_type st;
  crj_state_type next_st;
  // Two-stage reset synchroniser; only the second stage feeds any logic.
  logic          rst_meta_b;
  logic          rst_sync_b;

  if (CNT_W < 3) begin : g_chk
    $error("crj_regs: CNT_W must be at least 3");
  end

  // The fill threshold is a 32-bit constant, so a wider counter would lose its upper bits.
  if (CNT_W > 32) begin : g_chk_max
    $error("crj_regs: CNT_W must be at most 32");
  end

  // Only the low two byte lanes carry register bits; the upper lanes are dropped.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = old;
    if (be[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  // Returns {legal, n} for a rate code under a scaling mode.
  function automatic logic [4:0] scale_decode(input logic [1:0] mode, input logic [3:0] rate);
    scale_decode = {1'b0, 4'h1};
    case (mode)
      crj_pkg::MODE_NONE: begin
        // Mode 00 ignores the rate but still refuses codes above eight.
        if (rate <= crj_pkg::RATE_MAX) begin // [R7]
          scale_decode = {1'b1, 4'h1};
        end
      end
      crj_pkg::MODE_BOTH: begin
        // Rate one is reserved here; only two to eight reduce.
        if (rate >= 4'h2 && rate <= crj_pkg::RATE_MAX) begin // [R4] [R5]
          scale_decode = {1'b1, rate};
        end
      end
      crj_pkg::MODE_VSAMP: begin
        // Vertical sampling only works with power-of-two rates.
        if (rate == 4'h2 || rate == 4'h4 || rate == 4'h8) begin // [R8]
          scale_decode = {1'b1, rate};
        end
      end
      default: begin
        // Mode 11 refuses every rate.
        scale_decode = {1'b0, 4'h1}; // [R6] [R7]
      end
    endcase
  endfunction

  // Only four operation codes are defined; every other code is refused.
  function automatic logic op_legal(input logic [2:0] op);
    case (op)
      crj_pkg::OP_CAM_ENC,
      crj_pkg::OP_CAP_422,
      crj_pkg::OP_HOST,
      crj_pkg::OP_CAP_420: op_legal = 1'b1; // [R15]
      default:             op_legal = 1'b0;
    endcase
  endfunction

  // Both capture codes end in binary 11; either one gates off the codec clock,
  // so the codec registers cannot be reached until an encode or decode code returns.
  function automatic logic is_capture(input logic [2:0] op);
    is_capture = (op[1:0] == 2'h3); // [R16]
  endfunction

  // The quarter and half thresholds follow the configured size, not the physical depth, so software
  // can shrink the FIFO without this logic being retuned.
  function automatic logic [1:0] fill_level(input logic [CNT_W-1:0] cnt,
                                            input logic [CNT_W-1:0] size);
    if (cnt >= (size >> 1)) begin
      fill_level = crj_pkg::FILL_HALF; // [R22]
    end else if (cnt >= (size >> 2)) begin
      fill_level = crj_pkg::FILL_QUARTER; // [R21]
    end else if (cnt >= crj_pkg::FILL_MIN_BYTES[CNT_W-1:0]) begin
      fill_level = crj_pkg::FILL_SOME; // [R21]
    end else begin
      fill_level = crj_pkg::FILL_EMPTY; // [R21]
    end
  endfunction

  // Unmapped offsets read zero, so a stray read is harmless.
  function automatic logic [15:0] read_word(input crj_state_type s, input logic [7:0] a);
    read_word = 16'h0000;
    case (a)
      crj_pkg::OFS_START_Y: read_word = {5'h00, s.start_y};
      crj_pkg::OFS_END_X:   read_word = {5'h00, s.end_x};
      crj_pkg::OFS_END_Y:   read_word = {5'h00, s.end_y};
      crj_pkg::OFS_RATE:    read_word = s.rate;
      crj_pkg::OFS_MODE:    read_word = {14'h0000, s.mode};
      crj_pkg::OFS_CTRL: begin
        // The module reset bit is write only and always reads back zero.
        read_word[crj_pkg::CTL_FAST_BIT]   = s.fast;
        read_word[crj_pkg::CTL_MARKER_BIT] = s.marker;
        read_word[crj_pkg::CTL_ROT_BIT]    = s.rot;
        read_word[crj_pkg::CTL_UVOFF_BIT]  = s.uvoff;
        read_word[crj_pkg::CTL_OP_LSB +: 3] = s.op;
        read_word[crj_pkg::CTL_EN_BIT]     = s.en;
      end
      crj_pkg::OFS_STATUS: begin
        // Reserved bits 15 and 7 read as one; the other reserved bits read as zero.
        read_word = crj_pkg::STATUS_RSV_ONE;
        read_word[crj_pkg::ST_BUSY_BIT]      = s.busy; // [R20]
        read_word[crj_pkg::ST_FILL_LSB +: 2] = s.fill; // [R21] [R22]
        read_word[crj_pkg::ST_FLAG_LSB +: 4] = s.flags; // [R24]
        read_word[crj_pkg::ST_MARKER_BIT]    = s.flg_marker;
        read_word[crj_pkg::ST_OVF_BIT]       = s.flg_ovf; // [R24]
        read_word[crj_pkg::ST_CODEC_BIT]     = s.codec_irq;
        read_word[crj_pkg::ST_LB_BIT]        = s.lb_irq;
      end
      default: read_word = 16'h0000;
    endcase
  endfunction

  // The reset release is synchronised so every flop leaves reset on the same edge;
  // entry stays asynchronous so a stopped clock cannot hold stale state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  always_comb begin
    logic        req;
    logic        commit;
    logic        wr;
    logic [15:0] cur;
    logic [15:0] wv;
    logic [4:0]  sd;
    req    = read || write;
    commit = req && !st.waitreq;
    wr     = commit && write;
    cur    = read_word(st, address);
    wv     = merge(cur, writedata, byteenable);
    sd     = 5'h00;
    next_st = st;
    next_st.srst = 1'b0;

    // One wait state: data are prepared in the first cycle and the access commits
    // at the edge where waitrequest is seen low, so a write lands exactly once.
    // A held request sees waitrequest low for one cycle per access, and
    // back-to-back transfers need no idle cycle between them.
    if (req && st.waitreq) begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = {16'h0000, cur};
    end else if (commit) begin
      next_st.waitreq = 1'b1;
    end

    if (wr) begin
      case (address)
        // Window coordinates keep eleven bits; higher written bits are dropped.
        crj_pkg::OFS_START_Y: next_st.start_y = wv[10:0]; // [R3]
        crj_pkg::OFS_END_X:   next_st.end_x   = wv[10:0]; // [R1]
        crj_pkg::OFS_END_Y:   next_st.end_y   = wv[10:0]; // [R2]
        // The rate word is stored whole so software reads back what it wrote.
        crj_pkg::OFS_RATE:    next_st.rate    = wv;
        crj_pkg::OFS_MODE:    next_st.mode    = wv[1:0];
        crj_pkg::OFS_CTRL: begin
          next_st.fast   = wv[crj_pkg::CTL_FAST_BIT];
          next_st.marker = wv[crj_pkg::CTL_MARKER_BIT];
          // Rotation only reorders pixels within a line; software must reverse the
          // line order in the output file itself.
          next_st.rot    = wv[crj_pkg::CTL_ROT_BIT]; // [R11]
          next_st.uvoff  = wv[crj_pkg::CTL_UVOFF_BIT];
          next_st.op     = wv[crj_pkg::CTL_OP_LSB +: 3];
          next_st.en     = wv[crj_pkg::CTL_EN_BIT];
          // The reset bit is checked against the enable held before this write.
          next_st.srst   = wv[crj_pkg::CTL_SRST_BIT] && st.en; // [R12]
        end
        crj_pkg::OFS_STATUS: begin
          // Bits 14..12 are read only, so the ones software writes there are dropped.
          next_st.flags      = st.flags & ~wv[crj_pkg::ST_FLAG_LSB +: 4]; // [R24] [R25]
          next_st.flg_marker = st.flg_marker & ~wv[crj_pkg::ST_MARKER_BIT]; // [R24]
        end
        // Writes to unmapped offsets are dropped.
        default: next_st.srst = 1'b0;
      endcase
    end

    // Events are applied after the clears so a same-cycle set is never lost.
    // A size limit overrun is only a warning; encoding carries on with the flag up.
    next_st.flags[3] = next_st.flags[3] | size_limit_evt; // [R25]
    next_st.flags[2] = next_st.flags[2] | fifo_thresh_evt;
    next_st.flags[1] = next_st.flags[1] | fifo_full_evt;
    next_st.flags[0] = next_st.flags[0] | fifo_empty_evt;
    next_st.flg_marker = next_st.flg_marker | marker_evt;
    // The overflow flag has no software clear; only the module reset or rst_b empties it,
    // and an overflow in that same cycle still wins.
    if (st.srst) begin
      next_st.flg_ovf = 1'b0;
    end
    next_st.flg_ovf   = next_st.flg_ovf | lb_overflow_evt;
    // Status inputs are copied one cycle late so a read always sees settled values.
    next_st.codec_irq = codec_irq;
    next_st.lb_irq    = lb_irq;
    next_st.busy      = codec_busy; // [R20]
    next_st.fill      = fill_level(fifo_count, fifo_size); // [R21] [R22]

    sd            = scale_decode(next_st.mode, next_st.rate[3:0]);
    next_st.sc_ok = sd[4];
    next_st.div   = sd[3:0];
    next_st.op_ok = op_legal(next_st.op); // [R15]
    // Derived enables are registered here so every output comes straight from a flop.
    next_st.mk_fast  = next_st.fast & next_st.marker; // [R9]
    next_st.codec_en = next_st.en & ~is_capture(next_st.op); // [R16] [R18]

    // The valid bit follows the enable because the module clock is off without it;
    // the sample is still captured, which costs nothing and keeps the path simple.
    next_st.chroma_vld = chroma_in_vld && st.en;
    if (chroma_in_vld) begin
      next_st.chroma = st.uvoff ? chroma_in : (chroma_in ^ crj_pkg::CHROMA_FLIP); // [R14]
    end
  end

  // Divisor and legality flags reset to what the reset rate and mode decode to.
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st            <= '0;
      st.waitreq    <= 1'b1;
      st.start_y    <= crj_pkg::RST_START_Y;
      st.end_x      <= crj_pkg::RST_END_X; // [R1]
      st.end_y      <= crj_pkg::RST_END_Y; // [R2]
      st.rate       <= crj_pkg::RST_RATE;
      st.mode       <= crj_pkg::RST_MODE;
      st.div        <= 4'h1;
      st.sc_ok      <= 1'b1;
      st.op_ok      <= 1'b1;
      st.fill       <= crj_pkg::FILL_EMPTY;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a plain copy of a register, so nothing downstream sees a glitch.
  assign readdata        = st.rdata;
  assign waitrequest     = st.waitreq;
  assign chroma_out      = st.chroma;
  assign chroma_out_vld  = st.chroma_vld;
  assign win_start_y     = st.start_y;
  assign win_end_x       = st.end_x;
  assign win_end_y       = st.end_y;
  assign scale_mode      = st.mode;
  assign scale_div       = st.div;
  assign scale_ok        = st.sc_ok;
  assign huff_fast_en    = st.fast;
  assign marker_fast_en  = st.mk_fast; // [R9]
  assign rotate_en       = st.rot; // [R11]
  assign op_mode         = st.op;
  assign op_mode_ok      = st.op_ok;
  assign module_clk_en   = st.en; // [R18]
  assign codec_clk_en    = st.codec_en; // [R16] [R18]
  assign module_soft_rst = st.srst; // [R12]

endmodule // crj_regs

// file: shared/crj_pkg.sv
// Functional notes
// [R1] End X is 11 bits in the low bits, reset value 0x027F.
// [R2] End Y is 11 bits in the low bits, reset value 0x01DF.
// [R3] Start Y is an 11-bit starting vertical coordinate of the window.
// [R4] Rate codes 1 to 8 select 1/n; code 0 and codes 9 to 15 reserved. The code refuses code 1 in mode 01.
// [R5] Rates 1/3, 1/5, 1/6, 1/7 are valid only in mode 01.
// [R6] Mode 00 no scaling, 01 both directions, 10 V-sample H-average, 11 reserved.
// [R7] Mode 00 passes full scale for rates 0 to 8; mode 11 always reserved.
// [R8] Mode 10 supports only rates 1/2, 1/4 and 1/8.
// [R9] Marker fast output acts only while encode fast mode is set.
// [R10] Software loads default Huffman tables before using encode fast mode alone.
// [R11] Bit 8 enables 180 degree rotation within each line during encoding.
// [R12] Writing one to bit 7 resets the module, ignored while enable is zero.
// [R13] Software issues the module reset before every encode.
// [R14] Bit 4 zero flips chroma between unsigned and signed ranges; one passes it.
// [R15] Operation codes 000, 011, 100, 111 are valid; others reserved.
// [R16] Either capture mode gates off the codec clock.
// [R17] Software sets the resizer to at least one half for 4:4:4 encode.
// [R18] Clearing enable, reset zero, stops the module clock and codec access.
// [R19] Software clears module enable before disabling the resizer.
// [R20] Status bit 14 reads one while the codec output is busy.
// [R21] Status bits 13..12 give FIFO fill: empty, four bytes, quarter.
// [R22] FIFO fill reads 11 from half the configured size upward.
// [R23] Software writes ones into status bits 14 to 12.
// [R24] Flags 11..8 and 4 clear by writing one; flags 2..0 are read only.
// [R25] Size limit flag sets on overflow of the limit and clears by writing one.
package crj_pkg;

  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_START_Y    = 8'hCC;
  localparam logic [7:0]  OFS_END_X      = 8'hD0;
  localparam logic [7:0]  OFS_END_Y      = 8'hD4;
  localparam logic [7:0]  OFS_RATE       = 8'hD8;
  localparam logic [7:0]  OFS_MODE       = 8'hDC;

  localparam logic [10:0] RST_START_Y    = 11'h000;
  localparam logic [10:0] RST_END_X      = 11'h27F;
  localparam logic [10:0] RST_END_Y      = 11'h1DF;
  localparam logic [15:0] RST_RATE       = 16'h8080;
  localparam logic [1:0]  RST_MODE       = 2'h0;
  localparam logic [15:0] STATUS_RSV_ONE = 16'h8080;

  localparam int CTL_FAST_BIT   = 15;
  localparam int CTL_MARKER_BIT = 14;
  localparam int CTL_ROT_BIT    = 8;
  localparam int CTL_SRST_BIT   = 7;
  localparam int CTL_UVOFF_BIT  = 4;
  localparam int CTL_OP_LSB     = 1;
  localparam int CTL_EN_BIT     = 0;
  localparam int ST_BUSY_BIT    = 14;
  localparam int ST_FILL_LSB    = 12;
  localparam int ST_FLAG_LSB    = 8;
  localparam int ST_MARKER_BIT  = 4;
  localparam int ST_OVF_BIT     = 2;
  localparam int ST_CODEC_BIT   = 1;
  localparam int ST_LB_BIT      = 0;

  localparam logic [1:0]  MODE_NONE      = 2'h0;
  localparam logic [1:0]  MODE_BOTH      = 2'h1;
  localparam logic [1:0]  MODE_VSAMP     = 2'h2;
  localparam logic [3:0]  RATE_MAX       = 4'h8;
  localparam logic [7:0]  CHROMA_FLIP    = 8'h80;
  localparam logic [31:0] FILL_MIN_BYTES = 32'h4;

  localparam logic [2:0]  OP_CAM_ENC     = 3'h0;
  localparam logic [2:0]  OP_CAP_422     = 3'h3;
  localparam logic [2:0]  OP_HOST        = 3'h4;
  localparam logic [2:0]  OP_CAP_420     = 3'h7;

  localparam logic [1:0]  FILL_EMPTY     = 2'h0;
  localparam logic [1:0]  FILL_SOME      = 2'h1;
  localparam logic [1:0]  FILL_QUARTER   = 2'h2;
  localparam logic [1:0]  FILL_HALF      = 2'h3;

endpackage

// file: dv/crj_regs_asserts.sv
`timescale 1ns/10ps
module crj_regs_asserts (
  input wire logic       clk,             // System clock.
  input wire logic       rst_b,           // Reset, active low.
  input wire logic [7:0] chroma_in,       // Chroma in.
  input wire logic       chroma_in_vld,   // Chroma in valid.
  input wire logic [7:0] chroma_out,      // Chroma out.
  input wire logic       chroma_out_vld,  // Chroma out valid.
  input wire logic [1:0] scale_mode,      // Scaling mode.
  input wire logic [3:0] scale_div,       // Divisor.
  input wire logic       scale_ok,        // Scaling legal.
  input wire logic       huff_fast_en,    // Encode fast mode.
  input wire logic       marker_fast_en,  // Marker fast output.
  input wire logic [2:0] op_mode,         // Operation mode.
  input wire logic       op_mode_ok,      // Operation legal.
  input wire logic       module_clk_en,   // Module clock enable.
  input wire logic       codec_clk_en,    // Codec clock enable.
  input wire logic       module_soft_rst  // Module reset pulse.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Mode and divisor are registered on the same edge; only values held steady for a cycle are judged.
  sequence s_scale_settled;
    scale_ok && $stable(scale_mode) && $stable(scale_div) && $stable(scale_ok);
  endsequence
  sequence s_srst_once;
    module_soft_rst ##1 !module_soft_rst;
  endsequence

  chk_scale_legal: assert property (
    s_scale_settled |-> scale_mode != 2'h3 && (scale_mode != 2'h0 || scale_div == 4'h1)
    && scale_div inside {[4'h1:4'h8]}) else $error("scale legal with bad mode or divisor");
  chk_vsamp_rates: assert property (
    s_scale_settled and scale_mode == 2'h2 |-> scale_div inside {4'h2, 4'h4, 4'h8})
    else $error("vertical sampling mode took an odd rate");
  chk_odd_rates: assert property (
    s_scale_settled and scale_div inside {4'h3, 4'h5, 4'h6, 4'h7} |-> scale_mode == 2'h1)
    else $error("odd rate outside combined reduction");
  chk_marker_gate: assert property (
    marker_fast_en |-> huff_fast_en) else $error("marker fast without encode fast");
  chk_codec_gate: assert property (
    codec_clk_en == (module_clk_en && op_mode[1:0] != 2'h3))
    else $error("codec clock gate wrong");
  chk_op_legal: assert property (
    op_mode_ok == (op_mode inside {3'h0, 3'h3, 3'h4, 3'h7})) else $error("op legal flag wrong");
  chk_chroma_vld: assert property (
    chroma_in_vld |=> chroma_out_vld == $past(module_clk_en)) else $error("chroma valid wrong");
  chk_chroma_val: assert property (
    chroma_out_vld |-> $past(chroma_in_vld) && (chroma_out == $past(chroma_in)
    || chroma_out == ($past(chroma_in) ^ 8'h80))) else $error("chroma value wrong");
  chk_srst_pulse: assert property (
    $rose(module_soft_rst) |-> s_srst_once) else $error("module reset not one cycle");
endmodule // crj_regs_asserts

bind crj_regs crj_regs_asserts crj_regs_asserts_i (.*);

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk, rst_b, read, write, codec_busy, codec_irq, lb_irq, chroma_in_vld, ok;
  logic [7:0]  address, chroma_in, chroma_out;
  logic [31:0] writedata, readdata, q;
  logic [3:0]  byteenable, scale_div;
  logic [15:0] fifo_count, fifo_size, v;
  logic [10:0] win_start_y, win_end_x, win_end_y, wv [3];
  logic [2:0]  op_mode;
  logic [1:0]  scale_mode;
  logic [5:0]  evt;
  logic        waitrequest, chroma_out_vld, scale_ok, huff_fast_en, marker_fast_en, rotate_en;
  logic        op_mode_ok, module_clk_en, codec_clk_en, module_soft_rst;
  wire         size_limit_evt, fifo_thresh_evt, fifo_full_evt, fifo_empty_evt;
  wire         marker_evt, lb_overflow_evt;
  int          fails, checks, seed, srst_n, flg, i, m, r;
  int          sb [6] = '{2, 4, 8, 9, 10, 11};
  int          cnt [8] = '{0, 3, 4, 15, 16, 31, 32, 64};
  int          code [8] = '{0, 0, 1, 1, 2, 2, 3, 3};
  logic [7:0]  wofs [3] = '{crj_pkg::OFS_START_Y, crj_pkg::OFS_END_X, crj_pkg::OFS_END_Y};

  assign {size_limit_evt, fifo_thresh_evt, fifo_full_evt, fifo_empty_evt, marker_evt,
          lb_overflow_evt} = evt;
  crj_regs crj_regs_i (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (module_soft_rst === 1'b1) srst_n <= srst_n + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // The request is held until waitrequest is seen low; only the watchdog bounds the wait.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= {16'h0000, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #300000;
    fails++;
    test_done();
  end

  initial begin
    seed = 91134;
    {fails, checks, srst_n, flg} = '0;
    {rst_b, read, write, address, writedata, codec_busy, codec_irq, lb_irq} = '0;
    {evt, fifo_count, chroma_in, chroma_in_vld} = '0;
    byteenable = 4'hF;
    fifo_size = 16'h0040;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(crj_pkg::OFS_END_X, 16'h027F);
    rd(crj_pkg::OFS_END_Y, 16'h01DF);
    rd(crj_pkg::OFS_RATE, 16'h8080);
    rd(crj_pkg::OFS_MODE, 16'h0000);
    rd(crj_pkg::OFS_CTRL, 16'h0000);
    rd(crj_pkg::OFS_STATUS, 16'h8080);
    rd(8'h08, 16'h0000);
    for (i = 0; i < 3; i++) begin
      wv[i] = 11'($random(seed));
      bus(1'b1, wofs[i], {5'h00, wv[i]});
      rd(wofs[i], {5'h00, wv[i]});
    end
    chk(win_start_y, wv[0]);
    chk({win_end_x, win_end_y}, {wv[1], wv[2]});
    for (m = 0; m < 4; m++) for (r = 0; r < 16; r++) begin
      bus(1'b1, crj_pkg::OFS_RATE, 16'(r));
      bus(1'b1, crj_pkg::OFS_MODE, 16'(m));
      rd(crj_pkg::OFS_RATE, 16'(r));
      ok = (m == 0 && r <= 8) || (m == 1 && r >= 2 && r <= 8) || (m == 2 && r inside {2, 4, 8});
      chk({scale_mode, scale_ok}, {2'(m), ok});
      if (ok) chk(scale_div, (m == 0) ? 1 : r);
    end
    bus(1'b1, crj_pkg::OFS_RATE, 16'h0002);
    bus(1'b1, crj_pkg::OFS_MODE, 16'h0001);
    chk({scale_ok, scale_div}, {1'b1, 4'h2});
    for (i = 0; i < 16; i++) begin
      v = 16'($random(seed)) & 16'hC111;
      v[3:1] = i[2:0];
      bus(1'b1, crj_pkg::OFS_CTRL, v);
      rd(crj_pkg::OFS_CTRL, v);
      chk({huff_fast_en, marker_fast_en, rotate_en, op_mode, op_mode_ok, module_clk_en,
           codec_clk_en}, {v[15], v[15] & v[14], v[8], v[3:1], v[2] == v[1], v[0],
           v[0] & (v[2:1] != 2'h3)});
    end
    bus(1'b1, crj_pkg::OFS_CTRL, 16'h0000);
    bus(1'b1, crj_pkg::OFS_CTRL, 16'h0080);
    chk(srst_n, 0);
    evt <= 6'h01;
    @(posedge clk);
    evt <= 6'h00;
    rd(crj_pkg::OFS_STATUS, 16'h8084);
    bus(1'b1, crj_pkg::OFS_CTRL, 16'h0001);
    bus(1'b1, crj_pkg::OFS_CTRL, 16'h0081);
    @(posedge clk);
    chk(srst_n, 1);
    rd(crj_pkg::OFS_STATUS, 16'h8080);
    for (i = 0; i < 8; i++) begin
      v = (i == 7) ? 16'h0000 : (i >= 4) ? 16'h0011 : 16'h0001;
      bus(1'b1, crj_pkg::OFS_CTRL, v);
      r = $random(seed);
      chroma_in <= r[7:0];
      chroma_in_vld <= 1'b1;
      @(posedge clk);
      chroma_in_vld <= 1'b0;
      @(posedge clk);
      if (v[0]) chk({chroma_out_vld, chroma_out}, {1'b1, v[4] ? r[7:0] : r[7:0] ^ 8'h80});
      else chk(chroma_out_vld, 1'b0);
    end
    for (i = 0; i < 6; i++) begin
      evt <= 6'(1 << i);
      @(posedge clk);
      flg = flg | (1 << sb[i]);
    end
    evt <= 6'h00;
    for (i = 0; i < 8; i++) begin
      fifo_count <= 16'(cnt[i]);
      {lb_irq, codec_irq, codec_busy} <= i[2:0];
      repeat (2) @(posedge clk);
      rd(crj_pkg::OFS_STATUS, 16'h8080 | 16'(flg) | {1'b0, i[0], 2'(code[i]), 12'h000}
         | {14'h0000, i[1], i[2]});
    end
    // Bit 2 is read only, so the first write must leave every flag set.
    for (i = 0; i < 6; i++) begin
      bus(1'b1, crj_pkg::OFS_STATUS, 16'h7000 | 16'(1 << sb[i]));
      if (i > 0) flg = flg & ~(1 << sb[i]);
      rd(crj_pkg::OFS_STATUS, 16'hF083 | 16'(flg));
    end
    test_done();
  end
endmodule // tb
